// File: pkg/fptr_pkg.sv
/*
  Constants, state types and table contents for the parameter table ROM.
  Assumes a single 50 MHz system clock and serial pins sampled into that clock.
*/
package fptr_pkg;
  // Serial command framing.
  localparam logic [7:0] PARAM_TABLE_READ_CMD = 8'h5A;
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam logic [1:0] DUMMY_BYTES = 2'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [23:0] TABLE_BYTES = 24'h00000C;
  localparam logic [7:0] PAD_BYTE = 8'hFF;
  // First double word fields.
  localparam logic [1:0] ERASE_4K_UNIFORM = 2'h1;
  localparam logic [7:0] ERASE_4K_OP = 8'h20;
  localparam logic GRAN_64B = 1'h1;
  localparam logic VOL_WEN_REQ = 1'h0;
  localparam logic VOL_WEN_SEL = 1'h0;
  localparam logic [2:0] TOP_UNUSED = 3'h7;
  localparam logic [1:0] ADDR_3OR4 = 2'h1;
  localparam logic SUPPORTED = 1'h1;
  localparam logic [7:0] UNUSED_BYTE = 8'hFF;
  // Wait-state and mode-bit encodings.
  localparam logic [4:0] WAIT_NONE = 5'h00;
  localparam logic [4:0] WAIT_4 = 5'h04;
  localparam logic [4:0] WAIT_6 = 5'h06;
  localparam logic [4:0] WAIT_8 = 5'h08;
  localparam logic [4:0] WAIT_10 = 5'h0A;
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [7:0] QUAD_IO_OP = 8'hEB;
  localparam logic [7:0] QUAD_OUT_OP = 8'h6B;
  localparam logic [31:0] DENSITY_WORD = 32'h1FFFFFFF;
  localparam logic [31:0] CAP_WORD = {UNUSED_BYTE, SUPPORTED, SUPPORTED, SUPPORTED,
    SUPPORTED, SUPPORTED, ADDR_3OR4, SUPPORTED, ERASE_4K_OP, TOP_UNUSED,
    VOL_WEN_SEL, VOL_WEN_REQ, GRAN_64B, ERASE_4K_UNIFORM};
  localparam logic [31:0] QUAD_WORD = {QUAD_OUT_OP, MODE_NONE, WAIT_8,
    QUAD_IO_OP, MODE_2, WAIT_4};
  localparam logic [23:0] TABLE_BASE_DEF = 24'h000030;

  typedef enum logic [5:0] {
    PH_IDLE = 6'b000001,
    PH_CMD = 6'b000010,
    PH_ADDR = 6'b000100,
    PH_DUMMY = 6'b001000,
    PH_DATA = 6'b010000,
    PH_SKIP = 6'b100000
  } fptr_phase_t;

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [2:0] si_s;
    logic sclk_f;
    logic cs_f;
    fptr_phase_t ph;
    logic [2:0] bitc;
    logic [1:0] bytec;
    logic [7:0] shin;
    logic [23:0] addr;
    logic [7:0] tx;
    logic so;
    logic so_oe;
  } fptr_state_t;

  localparam fptr_state_t ST_RESET = '{sclk_s: 3'h0, cs_s: 3'h7, si_s: 3'h0,
    sclk_f: 1'h0, cs_f: 1'h1, ph: PH_IDLE, bitc: 3'h0, bytec: 2'h0,
    shin: 8'h00, addr: 24'h000000, tx: 8'hFF, so: 1'h0, so_oe: 1'h0};
endpackage

// File: logic/fptr_rom.sv
/*
  Parameter table ROM behind the serial flash pins, read with the
  parameter-read command. Assumes the serial clock is well below a third
  of clk, since all pins are oversampled through three flip-flops.
*/
`timescale 1ns/1ps
module fptr_rom #(
  parameter logic [23:0] TABLE_BASE = fptr_pkg::TABLE_BASE_DEF
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Serial pins from the host.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  // Serial data out with its enable.
  output logic so,
  output logic so_oe
);
  fptr_pkg::fptr_state_t q;
  fptr_pkg::fptr_state_t d;
  logic rise;
  logic fall;
  logic [7:0] rx_byte;

  // Bytes outside the table read as padding, like erased flash.
  function automatic logic [7:0] rd_byte(input logic [23:0] a);
    logic [23:0] off;
    logic [31:0] w;
    off = a - TABLE_BASE;
    case (off[3:2])
      2'h0: w = fptr_pkg::CAP_WORD;
      2'h1: w = fptr_pkg::DENSITY_WORD;
      default: w = fptr_pkg::QUAD_WORD;
    endcase
    if (off < fptr_pkg::TABLE_BYTES) begin
      rd_byte = w[{off[1:0], 3'h0} +: 8];
    end else begin
      rd_byte = fptr_pkg::PAD_BYTE;
    end
  endfunction

  // Only the second and third stages are looked at, never the first.
  assign rise = (q.sclk_s[1] == q.sclk_s[2]) && q.sclk_s[2] && !q.sclk_f;
  assign fall = (q.sclk_s[1] == q.sclk_s[2]) && !q.sclk_s[2] && q.sclk_f;
  assign rx_byte = {q.shin[6:0], q.si_s[2]};

  always_comb begin
    d = q;
    d.sclk_s = {q.sclk_s[1:0], sclk};
    d.cs_s = {q.cs_s[1:0], cs_n};
    d.si_s = {q.si_s[1:0], si};
    if (q.sclk_s[1] == q.sclk_s[2]) begin
      d.sclk_f = q.sclk_s[2];
    end
    if (q.cs_s[1] == q.cs_s[2]) begin
      d.cs_f = q.cs_s[2];
    end
    if (q.cs_f) begin
      // Deselect ends any read at once, even mid-byte.
      d.ph = fptr_pkg::PH_IDLE;
      d.bitc = 3'h0;
      d.bytec = 2'h0;
      d.so_oe = 1'b0;
    end else begin
      if (q.ph == fptr_pkg::PH_IDLE) begin
        d.ph = fptr_pkg::PH_CMD;
      end
      if (rise && q.ph != fptr_pkg::PH_DATA) begin
        d.shin = rx_byte;
        d.bitc = q.bitc + 3'h1;
        if (q.bitc == fptr_pkg::BIT_LAST) begin
          case (q.ph)
            fptr_pkg::PH_IDLE, fptr_pkg::PH_CMD: begin
              // Other commands belong to other blocks; stay silent.
              if (rx_byte == fptr_pkg::PARAM_TABLE_READ_CMD) begin
                d.ph = fptr_pkg::PH_ADDR;
              end else begin
                d.ph = fptr_pkg::PH_SKIP;
              end
              d.bytec = 2'h0;
            end
            fptr_pkg::PH_ADDR: begin
              d.addr = {q.addr[15:0], rx_byte};
              if (q.bytec == fptr_pkg::ADDR_BYTES - 2'h1) begin
                d.ph = fptr_pkg::PH_DUMMY;
                d.bytec = 2'h0;
              end else begin
                d.bytec = q.bytec + 2'h1;
              end
            end
            fptr_pkg::PH_DUMMY: begin
              if (q.bytec == fptr_pkg::DUMMY_BYTES - 2'h1) begin
                d.ph = fptr_pkg::PH_DATA;
                d.tx = rd_byte(q.addr);
                d.bytec = 2'h0;
              end else begin
                d.bytec = q.bytec + 2'h1;
              end
            end
            default: begin
              d.ph = q.ph;
            end
          endcase
        end
      end
      if (fall && q.ph == fptr_pkg::PH_DATA) begin
        // Data changes on the falling edge so it is stable at the next rise.
        d.so = q.tx[7];
        d.so_oe = 1'b1;
        d.tx = {q.tx[6:0], 1'b1};
        d.bitc = q.bitc + 3'h1;
        if (q.bitc == fptr_pkg::BIT_LAST) begin
          d.addr = q.addr + 24'h000001;
          d.tx = rd_byte(q.addr + 24'h000001);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= fptr_pkg::ST_RESET;
    end else begin
      q <= d;
    end
  end

  assign so = q.so;
  assign so_oe = q.so_oe;

  // Each table byte as the read path decodes it, so checks can pick out single fields.
  logic [7:0] tbl_byte [int'(fptr_pkg::TABLE_BYTES) + 1];
  for (genvar g = 0; g <= int'(fptr_pkg::TABLE_BYTES); g++) begin : g_tbl
    assign tbl_byte[g] = rd_byte(TABLE_BASE + 24'(g));
  end

  erase_4k_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[0][1:0] == 2'h1 &&
    tbl_byte[1] == 8'h20)
    else $error("4KB erase field or opcode wrong.");
  write_gran_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[0][2] == 1'h1)
    else $error("Write granularity bit wrong.");
  wen_req_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[0][3] == 1'h0)
    else $error("Volatile write enable bit wrong.");
  wen_select_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[0][4:3] == 2'h0)
    else $error("Write enable select bits wrong.");
  top_bits_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[0][7:5] == 3'h7 &&
    tbl_byte[0] == 8'hE5)
    else $error("First table byte wrong.");
  addr_width_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[2][2:1] == 2'h1)
    else $error("Address width field wrong.");
  read_flags_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[2] == 8'hFB &&
    tbl_byte[3] == 8'hFF)
    else $error("Read mode flag byte wrong.");
  quad_io_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[8] == 8'h44 &&
    tbl_byte[9] == 8'hEB)
    else $error("Quad I/O read settings wrong.");
  quad_out_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[10] == 8'h08 &&
    tbl_byte[11] == 8'h6B)
    else $error("Quad output read settings wrong.");
  wait_code_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[8][4:0] inside {5'h00, 5'h04, 5'h06, 5'h08, 5'h0A} &&
    tbl_byte[10][4:0] inside {5'h00, 5'h04, 5'h06, 5'h08, 5'h0A})
    else $error("Wait-state encoding illegal.");
  mode_code_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[8][7:5] inside {3'h0, 3'h2} &&
    tbl_byte[10][7:5] inside {3'h0, 3'h2})
    else $error("Mode-bit encoding illegal.");
  density_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[4] == 8'hFF && tbl_byte[5] == 8'hFF &&
    tbl_byte[6] == 8'hFF && tbl_byte[7] == 8'h1F)
    else $error("Density word wrong.");
  pad_byte_a: assert property (@(posedge clk) disable iff (!rstn)
    tbl_byte[int'(fptr_pkg::TABLE_BYTES)] == 8'hFF)
    else $error("Byte past the table not padded.");
  ph_onehot_a: assert property (@(posedge clk) disable iff (!rstn)
    $onehot(q.ph))
    else $error("Phase register not one-hot.");
  oe_in_data_a: assert property (@(posedge clk) disable iff (!rstn)
    so_oe |-> q.ph == fptr_pkg::PH_DATA)
    else $error("Output enabled outside the data phase.");
  skip_silent_a: assert property (@(posedge clk) disable iff (!rstn)
    q.ph == fptr_pkg::PH_SKIP |-> !so_oe)
    else $error("Output driven for a foreign command.");
  so_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !fall |=> $stable(so))
    else $error("Data output moved without a falling edge.");
  cmd_decode_a: assert property (@(posedge clk) disable iff (!rstn)
    rise && !q.cs_f && q.ph == fptr_pkg::PH_CMD && q.bitc == 3'h7
    |=> q.ph == fptr_pkg::PH_ADDR || q.ph == fptr_pkg::PH_SKIP)
    else $error("Opcode byte not decoded.");
  addr_step_a: assert property (@(posedge clk) disable iff (!rstn)
    fall && !q.cs_f && q.ph == fptr_pkg::PH_DATA && q.bitc == 3'h7
    |=> q.addr == $past(q.addr) + 24'h000001 && q.tx == rd_byte(q.addr))
    else $error("Next byte not fetched after eight bits.");
  data_load_a: assert property (@(posedge clk) disable iff (!rstn)
    q.ph == fptr_pkg::PH_DATA && $past(q.ph) == fptr_pkg::PH_DUMMY
    |-> q.tx == rd_byte(q.addr) && q.bitc == 3'h0)
    else $error("First data byte not loaded from address.");
  bit_out_a: assert property (@(posedge clk) disable iff (!rstn)
    fall && q.ph == fptr_pkg::PH_DATA && !q.cs_f |=> so == $past(q.tx[7]) && so_oe)
    else $error("Data bit not driven on falling edge.");
  release_a: assert property (@(posedge clk) disable iff (!rstn)
    q.cs_f |=> !so_oe && q.ph == fptr_pkg::PH_IDLE)
    else $error("Output still driven after deselect.");
  read_entered_c: cover property (@(posedge clk) disable iff (!rstn)
    q.ph == fptr_pkg::PH_DUMMY ##[1:1000] q.ph == fptr_pkg::PH_DATA);
  other_cmd_c: cover property (@(posedge clk) disable iff (!rstn)
    q.ph == fptr_pkg::PH_SKIP);
  abort_c: cover property (@(posedge clk) disable iff (!rstn)
    q.ph == fptr_pkg::PH_DATA ##1 q.ph == fptr_pkg::PH_IDLE);
  byte_step_c: cover property (@(posedge clk) disable iff (!rstn)
    fall && !q.cs_f && q.ph == fptr_pkg::PH_DATA && q.bitc == 3'h7);
endmodule // fptr_rom

// File: tb/fptr_host_model.sv
/*
  Host flash controller model that reads the parameter table over the serial pins.
  Assumes the bench pulses req with op, addr and nbits while busy is low.
*/
`timescale 1ns/1ps
module fptr_host_model (
  // Clock.
  input wire logic clk,
  // Request from the bench.
  input wire logic req,
  input wire logic [7:0] op,
  input wire logic [23:0] addr,
  input wire logic [6:0] nbits,
  // Serial pins.
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe,
  // Results.
  output logic busy,
  output logic rx_vld,
  output logic [7:0] rx_byte
);
  logic [39:0] hdr;
  logic [7:0] sh;
  int i;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    busy = 1'b0;
    rx_vld = 1'b0;
    rx_byte = 8'h00;
    sh = 8'h00;
  end
  always begin
    @(posedge clk);
    if (req === 1'b1 && !busy) begin
      busy <= 1'b1;
      hdr = {op, addr, 8'hA5};
      cs_n <= 1'b0;
      for (i = 0; i < 40 + nbits; i++) begin
        si <= (i < 40) ? hdr[39 - i] : ~si;
        repeat (6) @(posedge clk);
        sclk <= 1'b1;
        // A bit taken while the output is not enabled counts as unknown.
        sh = {sh[6:0], (so_oe === 1'b1) ? so : 1'bx};
        if (i >= 40 && (i - 40) % 8 == 7) begin
          rx_byte <= sh;
          rx_vld <= 1'b1;
        end
        @(posedge clk);
        rx_vld <= 1'b0;
        repeat (5) @(posedge clk);
        sclk <= 1'b0;
      end
      repeat (6) @(posedge clk);
      cs_n <= 1'b1;
      repeat (8) @(posedge clk);
      busy <= 1'b0;
    end else if (cs_n) begin
      // An idle data line keeps changing so a stray sample never looks valid.
      si <= ~si;
    end
  end
endmodule // fptr_host_model

// File: tb/flash_param_table_rom_bench.sv
/*
  Self-checking bench for the parameter table ROM with a host model partner.
  Assumes a 50 MHz clock and a table placed at a non-zero base address.
*/
`timescale 1ns/1ps
module flash_param_table_rom_bench;
  localparam logic [23:0] BASE = 24'h000100;
  logic clk, rstn, req, sclk, cs_n, si, so, so_oe, busy, rx_vld;
  logic [7:0] op, rx_byte, o;
  logic [23:0] addr;
  logic [6:0] nbits;
  logic [7:0] exp_q[$];
  logic [7:0] tab [12];
  logic [31:0] seed;
  int error_cnt, n_compared, cycles, k;
  fptr_rom #(.TABLE_BASE(BASE)) dut (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .si(si), .so(so), .so_oe(so_oe));
  fptr_host_model host (.clk(clk), .req(req), .op(op), .addr(addr), .nbits(nbits),
    .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .busy(busy),
    .rx_vld(rx_vld), .rx_byte(rx_byte));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic close_out();
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] got);
    logic [7:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hzz;
    n_compared++;
    if (got !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, e);
    end
  endtask
  // A refused frame expects unknown bytes, since the output must stay disabled.
  task automatic read_frame(input logic [7:0] c, input logic [23:0] a, input int bits);
    int b, off;
    for (b = 0; b < bits / 8; b++) begin
      off = int'(a) + b - int'(BASE);
      exp_q.push_back(c != 8'h5A ? 8'hxx : (off >= 0 && off < 12) ? tab[off] : 8'hFF);
    end
    @(negedge clk);
    op = c;
    addr = a;
    nbits = bits[6:0];
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    while (busy === 1'b1) @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      close_out();
    end
  end
  always @(posedge clk) if (rx_vld === 1'b1) cmp_byte(rx_byte);
  initial begin
    {rstn, req, op, addr, nbits, seed} = {1'b0, 1'b0, 8'h00, 24'h000000, 7'h00, 32'h4E6D1BCB};
    tab[0] = {3'b111, 1'b0, 1'b0, 1'b1, 2'b01};
    tab[1] = 8'h20;
    tab[2] = {1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'b01, 1'b1};
    tab[3] = 8'hFF;
    {tab[7], tab[6], tab[5], tab[4]} = 32'h1FFFFFFF;
    tab[8] = {3'b010, 5'b00100};
    tab[9] = 8'hEB;
    tab[10] = {3'b000, 5'b01000};
    tab[11] = 8'h6B;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    read_frame(8'h5A, BASE, 96);
    read_frame(8'h5A, BASE + 24'h4, 12);
    for (k = 0; k < 8; k++) begin
      seed = xs(seed);
      read_frame(8'h5A, BASE + 24'(seed[3:0]) - 24'h2, 8 * (1 + seed[5:4]));
    end
    seed = xs(seed);
    o = (seed[7:0] == 8'h5A) ? 8'h5B : seed[7:0];
    read_frame(o, BASE, 16);
    read_frame(8'h5A, BASE + 24'h8, 32);
    repeat (4) @(negedge clk);
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: bytes missing", $time);
    end
    close_out();
  end
endmodule // flash_param_table_rom_bench
